// ===== design/mute_and_peak_limiter.sv
// Soft mute, silence auto-mute and dynamic peak limiter for seven channels.
//
// The APB slave port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "limiter_regs.svh"

module mute_and_peak_limiter
  import limiter_pkg::*;
#(
  parameter int ZC_TIMEOUT_CYCLES = `ZC_TIMEOUT_MS * (`MCLK_HZ / 1000)
) (
  // Clock and reset.
  input  wire logic         mclk,
  input  wire logic         rst_b,
  // APB register port.
  input  wire logic         psel,
  input  wire logic         penable,
  input  wire logic         pwrite,
  input  wire logic [9:0]   paddr,
  input  wire logic [31:0]  pwdata,
  output logic              pready,
  output logic [31:0]       prdata,
  output logic              pslverr,
  // Zero-cross settings shared with the volume control.
  input  wire logic [3:0]   crossing_detect,
  input  wire logic         crossing_timeout_enable,
  // Sample stream from the volume control.
  input  wire logic         in_valid,
  input  wire audio_frame_t in_frame,
  // Sample stream and mutes toward the modulator and output stage.
  output logic              out_valid,
  output audio_frame_t      out_frame,
  output logic [2:0]        stage_mute,
  output logic              lowfreq_quiet
);

  // --------------------------------------------------------------------------
  // Reset synchroniser
  // --------------------------------------------------------------------------
  logic       rst_meta_reg;
  logic       rst_sync_b;

  // Assertion is immediate, release comes two edges later.
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rst_meta_reg <= 1'b0;
      rst_sync_b   <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_b   <= rst_meta_reg;
    end
  end

  // --------------------------------------------------------------------------
  // APB slave
  // --------------------------------------------------------------------------
  logic [8:0]  mute_control_reg;
  logic [8:0]  limiter_enables_reg;
  logic [8:0]  limiter_parameters_reg;
  logic [31:0] status_word;
  logic [7:0]  reg_idx;
  logic        idx_hit;
  logic        apb_commit;

  assign reg_idx    = paddr[9:2];
  assign idx_hit    = (paddr[1:0] == 2'h0) &&
                      (reg_idx == `REG_MUTE_IDX ||
                       reg_idx == `REG_LIM_EN_IDX ||
                       reg_idx == `REG_LIM_PAR_IDX ||
                       reg_idx == `REG_STATUS_IDX);
  assign apb_commit = psel && penable && pready;

  // Answer in the first access cycle; data and error are set up at setup.
  always_ff @(posedge mclk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0;
    end else begin
      pready  <= psel && !penable && !pready;
      if (psel && !penable) begin
        pslverr <= !idx_hit;
        prdata  <= 32'h0;
        if (!pwrite && paddr[1:0] == 2'h0) begin
          case (reg_idx)
            `REG_MUTE_IDX:    prdata <= {23'h0, mute_control_reg};
            `REG_LIM_EN_IDX:  prdata <= {23'h0, limiter_enables_reg};
            `REG_LIM_PAR_IDX: prdata <= {23'h0, limiter_parameters_reg};
            `REG_STATUS_IDX:  prdata <= status_word;
            default:          prdata <= 32'h0;
          endcase
        end
      end
    end
  end

  // Writes take effect only at the completing edge of the access.
  always_ff @(posedge mclk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      mute_control_reg       <= `MUTE_RESET;
      limiter_enables_reg    <= `LIM_EN_RESET;
      limiter_parameters_reg <= `LIM_PAR_RESET;
    end else if (apb_commit && pwrite && paddr[1:0] == 2'h0) begin
      case (reg_idx)
        `REG_MUTE_IDX:    mute_control_reg       <= pwdata[8:0];
        `REG_LIM_EN_IDX:  limiter_enables_reg    <= pwdata[8:0];
        `REG_LIM_PAR_IDX: limiter_parameters_reg <= pwdata[8:0];
        default:          ;
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // Common settings decoded once for all channels
  // --------------------------------------------------------------------------
  logic        soft_mute_on;
  logic        per_channel;
  logic [2:0]  atk_code;
  logic [2:0]  dcy_code;
  logic [1:0]  thr_code;
  logic        freq_dependent_release_on;
  logic [23:0] limit_level;
  logic [4:0]  attack_shift;
  logic [4:0]  release_shift;

  assign soft_mute_on = mute_control_reg[`SOFT_MUTE_BIT];
  assign per_channel  = limiter_enables_reg[`PER_CHANNEL_BIT];
  assign atk_code     = limiter_parameters_reg[`ATK_LSB +: 3];
  assign dcy_code     = limiter_parameters_reg[`DCY_LSB +: 3];
  assign thr_code     = limiter_parameters_reg[`THR_LSB +: 2];
  assign freq_dependent_release_on      = limiter_parameters_reg[`FREQ_DEPENDENT_RELEASE_BIT];

  // Each code step doubles the time, so it adds one to the shift; release codes above RELEASE_MAX_CODE add no more.
  always_comb begin
    case (thr_code)
      2'b00:   limit_level = `LEVEL_M12DB;
      2'b01:   limit_level = `LEVEL_M9DB;
      2'b10:   limit_level = `LEVEL_M6DB;
      default: limit_level = `LEVEL_M3DB;
    endcase
    attack_shift  = `ATTACK_BASE_SHIFT + {2'h0, atk_code};
    if (dcy_code > `RELEASE_MAX_CODE) begin
      release_shift = `RELEASE_BASE_SHIFT + {2'h0, `RELEASE_MAX_CODE};
    end else begin
      release_shift = `RELEASE_BASE_SHIFT + {2'h0, dcy_code};
    end
  end

  // --------------------------------------------------------------------------
  // Per-channel path: soft mute, peak detect, gain law, zero-cross hold
  // --------------------------------------------------------------------------
  localparam logic [22:0] ZC_LAST = 23'(ZC_TIMEOUT_CYCLES - 1);

  sample_t     soft_val   [7];
  logic [27:0] target_w   [7];
  logic        over_w     [7];
  logic        under_w    [7];
  sample_t     y_w        [7];
  logic [6:0]  active_w;

  for (genvar i = 0; i < 7; i++) begin : g_chan
    localparam int PAIR    = (i < 6) ? i / 2 : 3;
    localparam int PARTNER = (i < 6) ? (i ^ 1) : i;
    localparam bit FOLLOW  = (i < 6) && ((i % 2) == 1);

    sample_t           x_in;
    sample_t           prev_in_reg;
    sample_t           hold_reg;
    logic              soft_act_reg;
    sample_t           decay_step;
    logic [23:0]       mag;
    logic [23:0]       peak_reg;
    logic [23:0]       peak_next;
    logic [51:0]       peak_prod;
    logic [27:0]       target_reg;
    logic [27:0]       applied_reg;
    logic [27:0]       target_next;
    logic [4:0]        rel_shift_ch;
    logic signed [52:0] out_prod;
    logic              sign_prev_reg;
    logic              crossing;
    logic [7:0]        interval_reg;
    logic              lowfreq_reg;
    logic [22:0]       wait_cnt_reg;
    logic              lim_on;
    logic              go_down;
    logic              go_up;

    assign x_in       = in_frame.ch[i];
    // Held value starts from the last input before mute was raised.
    assign soft_val[i] = !soft_mute_on ? x_in :
                         (soft_act_reg ? hold_reg : prev_in_reg);
    assign decay_step = soft_val[i] >>> `SOFT_DECAY_SHIFT;

    // Soft mute: y -= y/64 per sample; small positive values snap to zero
    // because the arithmetic shift would otherwise leave them stuck.
    always_ff @(posedge mclk or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
        prev_in_reg  <= '0;
        hold_reg     <= '0;
        soft_act_reg <= 1'b0;
      end else if (in_valid) begin
        prev_in_reg  <= x_in;
        soft_act_reg <= soft_mute_on;
        if (decay_step == '0) begin
          hold_reg <= '0;
        end else begin
          hold_reg <= soft_val[i] - decay_step;
        end
      end
    end

    // Peak detector: instant rise, slow fall, on the soft-mute output.
    assign mag       = soft_val[i][23] ? 24'(-soft_val[i]) : 24'(soft_val[i]);
    assign peak_next = (mag > peak_reg - (peak_reg >> `PEAK_DECAY_SHIFT)) ?
                       mag : peak_reg - (peak_reg >> `PEAK_DECAY_SHIFT);
    assign peak_prod = peak_next * target_reg;
    assign over_w[i]  = peak_prod[51:`GAIN_FRAC] > {1'b0, limit_level};
    assign under_w[i] = peak_prod[51:`GAIN_FRAC] < {1'b0, limit_level};

    always_ff @(posedge mclk or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
        peak_reg <= '0;
      end else if (in_valid) begin
        peak_reg <= peak_next;
      end
    end

    // Frequency estimate: samples between sign changes.
    assign crossing = (soft_val[i] == '0) || (soft_val[i][23] != sign_prev_reg);

    always_ff @(posedge mclk or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
        sign_prev_reg <= 1'b0;
        interval_reg  <= '0;
        lowfreq_reg   <= 1'b0;
      end else if (in_valid) begin
        sign_prev_reg <= soft_val[i][23];
        if (crossing) begin
          interval_reg <= '0;
          lowfreq_reg  <= interval_reg >= `LOWFREQ_SAMPLES;
        end else if (interval_reg != 8'hff) begin
          interval_reg <= interval_reg + 8'h1;
        end else begin
          lowfreq_reg  <= 1'b1;
        end
      end
    end

    // Gain law: multiplicative step per sample, linked pairs share a gain.
    assign lim_on       = limiter_enables_reg[PAIR];
    assign rel_shift_ch = (freq_dependent_release_on && lowfreq_reg) ?
                          release_shift + `FREQ_DEPENDENT_RELEASE_EXTRA_SHIFT : release_shift;
    assign go_down = per_channel ? over_w[i] : (over_w[i] || over_w[PARTNER]);
    assign go_up   = per_channel ? under_w[i] :
                     (under_w[i] && under_w[PARTNER]);
    assign target_w[i] = target_reg;

    always_comb begin
      target_next = target_reg;
      if (!lim_on) begin
        target_next = `UNITY_GAIN;
      end else if (!per_channel && FOLLOW) begin
        target_next = target_w[PARTNER];
      end else if (go_down) begin
        target_next = target_reg - (target_reg >> attack_shift);
      end else if (go_up) begin
        target_next = target_reg + (target_reg >> rel_shift_ch);
        if (target_next > `UNITY_GAIN) begin
          target_next = `UNITY_GAIN;
        end
      end
    end

    always_ff @(posedge mclk or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
        target_reg <= `UNITY_GAIN;
      end else if (in_valid) begin
        target_reg <= target_next;
      end
    end

    // Held change lands on a crossing, when detection is off, or on timeout.
    always_ff @(posedge mclk or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
        applied_reg  <= `UNITY_GAIN;
        wait_cnt_reg <= '0;
      end else if (applied_reg == target_reg) begin
        wait_cnt_reg <= '0;
      end else if (crossing_timeout_enable && wait_cnt_reg == ZC_LAST) begin
        applied_reg  <= target_reg;
        wait_cnt_reg <= '0;
      end else begin
        wait_cnt_reg <= wait_cnt_reg + 23'h1;
        if (in_valid && (!crossing_detect[PAIR] || crossing)) begin
          applied_reg  <= target_reg;
          wait_cnt_reg <= '0;
        end
      end
    end

    // Gain never exceeds unity, so the product cannot pass full scale.
    assign out_prod = soft_val[i] * $signed({1'b0, applied_reg});
    assign y_w[i]   = out_prod[50:`GAIN_FRAC];
    assign active_w[i] = applied_reg != `UNITY_GAIN;
  end

  // --------------------------------------------------------------------------
  // Silence detection per pair (front, surround, centre, sub)
  // --------------------------------------------------------------------------
  logic [3:0] silent_w;

  for (genvar p = 0; p < 4; p++) begin : g_pair
    localparam int LO = (p < 3) ? 2 * p : 6;
    localparam int HI = (p < 3) ? 2 * p + 1 : 6;

    logic [10:0] zero_cnt_reg;
    logic        silent_reg;
    logic        silent_next;
    logic        all_zero;

    // Soft mute feeds zeros here, which is what lets it mute the stage.
    assign all_zero = (soft_val[LO] == '0) && (soft_val[HI] == '0);

    // Next flag is formed here so the stage mute moves with the same frame.
    assign silent_next =
      !mute_control_reg[`AMUTE_LSB + p] ? 1'b0 :
      !in_valid ? silent_reg :
      (all_zero && zero_cnt_reg >= `SILENCE_LAST);

    always_ff @(posedge mclk or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
        zero_cnt_reg <= '0;
        silent_reg   <= 1'b0;
      end else begin
        silent_reg <= silent_next;
        if (in_valid && !all_zero) begin
          zero_cnt_reg <= '0;
        end else if (in_valid && zero_cnt_reg != `SILENCE_SAMPLES) begin
          zero_cnt_reg <= zero_cnt_reg + 11'h1;
        end
      end
    end

    assign silent_w[p] = silent_next;
  end

  // --------------------------------------------------------------------------
  // Output registers
  // --------------------------------------------------------------------------
  // Stream and mutes leave from flops one cycle after the input strobe.
  always_ff @(posedge mclk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      out_valid     <= 1'b0;
      out_frame     <= '0;
      stage_mute    <= 3'h0;
      lowfreq_quiet <= 1'b0;
    end else begin
      out_valid     <= in_valid;
      stage_mute    <= silent_w[2:0];
      lowfreq_quiet <= silent_w[3];
      if (in_valid) begin
        for (int c = 0; c < 7; c++) begin
          out_frame.ch[c] <= y_w[c];
        end
      end
    end
  end

  // Status word: output-stage mutes, sub quiet and channels under limiting.
  assign status_word = {21'h0, active_w, silent_w};

endmodule : mute_and_peak_limiter
`default_nettype wire

// ===== design/limiter_regs.svh
// Register map, field positions, reset values and constants of the limiter.
`ifndef LIMITER_REGS_SVH
`define LIMITER_REGS_SVH

// ----------------------------------------------------------------------------
// Register indexes (byte address is four times the index)
// ----------------------------------------------------------------------------
`define REG_MUTE_IDX       8'h0c
`define REG_LIM_EN_IDX     8'h15
`define REG_LIM_PAR_IDX    8'h16
`define REG_STATUS_IDX     8'h1a

// ----------------------------------------------------------------------------
// Reset values and field positions
// ----------------------------------------------------------------------------
`define MUTE_RESET         9'h01e
`define LIM_EN_RESET       9'h00f
`define LIM_PAR_RESET      9'h0da
`define SOFT_MUTE_BIT      0
`define AMUTE_LSB          1
`define PER_CHANNEL_BIT    4
`define ATK_LSB            0
`define DCY_LSB            3
`define THR_LSB            6
`define FREQ_DEPENDENT_RELEASE_BIT           8
`define STAT_QUIET_BIT     3
`define STAT_ACTIVE_LSB    4

// ----------------------------------------------------------------------------
// Gain arithmetic and limit levels (full scale is 24'h7fffff)
// ----------------------------------------------------------------------------
`define GAIN_FRAC          27
`define UNITY_GAIN         28'h8000000
`define LEVEL_M12DB        24'h2026f3
`define LEVEL_M9DB         24'h2d6a86
`define LEVEL_M6DB         24'h404de6
`define LEVEL_M3DB         24'h5a9df7

// ----------------------------------------------------------------------------
// Per-sample time constants (48 kHz sample rate assumed for the shifts)
// ----------------------------------------------------------------------------
`define ATTACK_BASE_SHIFT  5'd4
`define RELEASE_BASE_SHIFT 5'd14
`define RELEASE_MAX_CODE   3'd5
`define FREQ_DEPENDENT_RELEASE_EXTRA_SHIFT   5'd2
`define SOFT_DECAY_SHIFT   6
`define PEAK_DECAY_SHIFT   8
`define SILENCE_LAST       11'd1023
`define SILENCE_SAMPLES    11'd1024
`define LOWFREQ_SAMPLES    8'd240
`define ZC_TIMEOUT_MS      25
`define MCLK_HZ            200000000

`endif

// ===== design/limiter_pkg.sv
// Types shared by the mute and peak limiter stage.
package limiter_pkg;

  // One signed 24-bit audio sample.
  typedef logic signed [23:0] sample_t;

  // One frame of seven channels: 0 FL, 1 FR, 2 SL, 3 SR, 4 FC, 5 RC, 6 SUB.
  typedef struct packed {
    sample_t [6:0] ch;
  } audio_frame_t;

endpackage : limiter_pkg

// ===== dv/limiter_assertions.sv
// Port-level checker for the mute and peak limiter stage.
`timescale 1ns/1ps
`default_nettype none
module limiter_checker
  import limiter_pkg::*;
(
  // Clock and reset.
  input wire logic         mclk,
  input wire logic         rst_b,
  // APB register port.
  input wire logic         psel,
  input wire logic         penable,
  input wire logic         pwrite,
  input wire logic [9:0]   paddr,
  input wire logic [31:0]  pwdata,
  input wire logic         pready,
  // Sample streams and mutes.
  input wire logic         in_valid,
  input wire audio_frame_t in_frame,
  input wire logic         out_valid,
  input wire audio_frame_t out_frame,
  input wire logic [2:0]   stage_mute,
  input wire logic         lowfreq_quiet
);
  // ------------------------------------------------------------------
  // Helper state
  // ------------------------------------------------------------------
  logic        soft_silence_ctl_reg;
  logic [10:0] quiet_reg;

  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);

  // Magnitude in 25 bits, so full negative scale does not wrap.
  function automatic logic [24:0] mag(input sample_t s);
    return s[23] ? 25'(-{s[23], s}) : {1'b0, s};
  endfunction

  // Shadow of the soft mute bit, taken when the APB write lands.
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      soft_silence_ctl_reg <= 1'b0;
    end else if (psel && penable && pready && pwrite && paddr == 10'h030) begin
      soft_silence_ctl_reg <= pwdata[0];
    end
  end

  // Silent front frames in a row; saturates so it never wraps to zero.
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      quiet_reg <= '0;
    end else if (out_valid) begin
      if (out_frame.ch[0] != 0 || out_frame.ch[1] != 0) begin
        quiet_reg <= '0;
      end else if (quiet_reg != 11'h7ff) begin
        quiet_reg <= quiet_reg + 11'd1;
      end
    end
  end

  // ------------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------------
  a_out_after_in: assert property (in_valid |=> out_valid)
    else $error("No output frame after an input frame.");
  a_out_has_cause: assert property (out_valid |-> $past(in_valid))
    else $error("Output frame without an input frame.");
  a_frame_held: assert property (!out_valid |-> $stable(out_frame))
    else $error("Output frame changed between frames.");
  a_front_release: assert property (
    out_valid && (out_frame.ch[0] != 0 || out_frame.ch[1] != 0)
    |-> !stage_mute[0])
    else $error("Front stage muted while front carries signal.");
  a_sub_release: assert property (
    out_valid && out_frame.ch[6] != 0 |-> !lowfreq_quiet)
    else $error("Sub noise cut while sub carries signal.");
  a_front_silence: assert property (
    $rose(stage_mute[0]) |-> out_valid && quiet_reg >= 11'd1023)
    else $error("Front stage muted before 1024 silent frames.");
  a_sub_quiet_edge: assert property (
    $rose(lowfreq_quiet) |-> out_valid && out_frame.ch[6] == 0)
    else $error("Sub noise cut outside a silent frame.");
  a_no_gain_up: assert property (
    out_valid && !soft_silence_ctl_reg
    |-> mag(out_frame.ch[0]) <= mag($past(in_frame.ch[0])))
    else $error("Output larger than its input sample.");
  a_apb_answer: assert property (psel && !penable |=> pready)
    else $error("No APB answer one cycle after setup.");
endmodule : limiter_checker

bind mute_and_peak_limiter limiter_checker limiter_checker_inst (
  .mclk(mclk), .rst_b(rst_b), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
  .in_valid(in_valid), .in_frame(in_frame), .out_valid(out_valid),
  .out_frame(out_frame), .stage_mute(stage_mute),
  .lowfreq_quiet(lowfreq_quiet)
);
`default_nettype wire

// ===== dv/volume_source_model.sv
// Model of the volume control output: one frame per bench request.
`timescale 1ns/1ps
`default_nettype none
module volume_source_model
  import limiter_pkg::*;
(
  // Clock and reset.
  input  wire logic         mclk,
  input  wire logic         rst_b,
  // Request from the bench.
  input  wire logic         send,
  input  wire audio_frame_t frame,
  // Stream toward the limiter.
  output logic              in_valid,
  output audio_frame_t      in_frame
);
  // Valid lasts one cycle; afterwards the data shows the inverse of the
  // last frame, so a stale sample can never pass for a fresh one.
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      in_valid <= 1'b0;
      in_frame <= '0;
    end else if (send) begin
      in_valid <= 1'b1;
      in_frame <= frame;
    end else begin
      in_valid <= 1'b0;
      in_frame <= in_valid ? ~in_frame : in_frame;
    end
  end
endmodule : volume_source_model
`default_nettype wire

// ===== dv/test_mute_and_peak_limiter.sv
// Self-checking bench for the mute and peak limiter stage.
`timescale 1ns/1ps
`default_nettype none
module test_mute_and_peak_limiter
  import limiter_pkg::*;
;
  logic         mclk = 1'b0;
  logic         rst_b = 1'b0;
  logic         psel = 1'b0;
  logic         penable = 1'b0;
  logic         pwrite = 1'b0;
  logic [9:0]   paddr = '0;
  logic [31:0]  pwdata = '0;
  logic [3:0]   crossing_detect = 4'h0;
  logic         crossing_timeout_enable = 1'b1;
  logic         send = 1'b0;
  audio_frame_t frm = '0;
  logic         pready, pslverr, in_valid, out_valid, lowfreq_quiet, e;
  logic [31:0]  prdata, r;
  logic [2:0]   stage_mute;
  audio_frame_t in_frame, out_frame, o, f;
  int           n_errors = 0;
  int           samples_checked = 0;

  always #2.5 mclk = ~mclk;

  mute_and_peak_limiter #(.ZC_TIMEOUT_CYCLES(64)) mute_and_peak_limiter_inst (
    .mclk(mclk), .rst_b(rst_b), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .crossing_detect(crossing_detect),
    .crossing_timeout_enable(crossing_timeout_enable),
    .in_valid(in_valid), .in_frame(in_frame), .out_valid(out_valid),
    .out_frame(out_frame), .stage_mute(stage_mute),
    .lowfreq_quiet(lowfreq_quiet)
  );
  volume_source_model volume_source_model_inst (
    .mclk(mclk), .rst_b(rst_b), .send(send), .frame(frm),
    .in_valid(in_valid), .in_frame(in_frame)
  );

  // ------------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic report_and_stop;
    $display("Mismatches %0d of %0d checks", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : report_and_stop

  // Reset is held 20 cycles; the release needs 2 edges, and 3 are waited before traffic.
  task automatic do_reset;
    @(posedge mclk);
    rst_b <= 1'b0;
    repeat (20) @(posedge mclk);
    rst_b <= 1'b1;
    repeat (3) @(posedge mclk);
  endtask : do_reset

  // One APB transfer; the request stands until pready is seen high.
  task automatic apb(input logic wr, input logic [9:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 16) begin
      n_errors++;
      report_and_stop();
    end
  endtask : apb

  // Sends one frame and takes the frame that comes back.
  task automatic io(input audio_frame_t fi);
    int n;
    @(posedge mclk);
    send <= 1'b1;
    frm <= fi;
    @(posedge mclk);
    send <= 1'b0;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (out_valid !== 1'b1 && n < 8);
    o = out_frame;
    if (n >= 8) begin
      n_errors++;
      report_and_stop();
    end
  endtask : io

  // Odd channels negative, so both signs cross the arithmetic.
  function automatic audio_frame_t mk(input sample_t b);
    audio_frame_t t;
    for (int i = 0; i < 7; i++) begin
      t.ch[i] = sample_t'(i % 2 ? -(b * (i + 1)) : b * (i + 1));
    end
    return t;
  endfunction : mk

  // ------------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------------
  initial begin
    do_reset();
    apb(1'b0, 10'h030, 32'h0);
    chk(r, 32'h1e);
    apb(1'b0, 10'h054, 32'h0);
    chk(r, 32'h0f);
    apb(1'b0, 10'h058, 32'h0);
    chk(r, 32'hda);
    apb(1'b0, 10'h3fc, 32'h0);
    chk(32'(e), 32'h1);
    apb(1'b1, 10'h058, 32'h1ff);
    apb(1'b0, 10'h058, 32'h0);
    chk(r, 32'h1ff);
    // Quiet signal passes untouched, then soft mute holds and decays.
    f = mk(24'h040000);
    io(f);
    for (int i = 0; i < 7; i++) chk(o.ch[i], f.ch[i]);
    apb(1'b1, 10'h030, 32'h1f);
    io(mk(24'h020000));
    for (int i = 0; i < 7; i++) chk(o.ch[i], f.ch[i]);
    io(mk(24'h020000));
    for (int i = 0; i < 7; i++) chk(o.ch[i], f.ch[i] - (f.ch[i] >>> 6));
    apb(1'b1, 10'h030, 32'h1e);
    f = mk(24'h030000);
    io(f);
    for (int i = 0; i < 7; i++) chk(o.ch[i], f.ch[i]);
    // Silence detection, restart of the count and release.
    repeat (1023) io('0);
    chk(32'({stage_mute, lowfreq_quiet}), 32'h0);
    io('0);
    chk(32'({stage_mute, lowfreq_quiet}), 32'hf);
    f = '0;
    f.ch[0] = 24'h000100;
    io(f);
    chk(32'({stage_mute, lowfreq_quiet}), 32'hd);
    repeat (1023) io('0);
    chk(32'(stage_mute), 32'h6);
    io('0);
    chk(32'(stage_mute), 32'h7);
    apb(1'b1, 10'h030, 32'h1c);
    repeat (2) io('0);
    chk(32'(stage_mute), 32'h6);
    // Soft mute silences every channel; only pairs with auto-mute on mute the stage.
    f = mk(24'h040000);
    io(f);
    apb(1'b1, 10'h030, 32'h1d);
    repeat (1800) io(f);
    chk(32'(stage_mute), 32'h6);
    chk(o.ch[1], 32'h0);
    // Linked pairs share the reduced gain.
    do_reset();
    f = mk(24'h020000);
    f.ch[0] = 24'h7fffff;
    repeat (60) io(f);
    chk(32'(o.ch[0] < f.ch[0]), 32'h1);
    chk(32'(o.ch[1] > f.ch[1]), 32'h1);
    // Only the limited front pair reports a gain below unity.
    apb(1'b0, 10'h068, 32'h0);
    chk(r, 32'h30);
    // Per-channel limiting, surround pair limiter off.
    do_reset();
    apb(1'b1, 10'h054, 32'h1d);
    f.ch[2] = 24'h7fffff;
    repeat (60) io(f);
    chk(o.ch[1], f.ch[1]);
    chk(32'(o.ch[0] < f.ch[0]), 32'h1);
    chk(o.ch[2], f.ch[2]);
    // A DC input never crosses, so the cut waits, then lands on timeout.
    do_reset();
    crossing_detect <= 4'h1;
    f = mk(24'h020000);
    f.ch[0] = 24'h7fffff;
    repeat (2) io(f);
    chk(o.ch[0], f.ch[0]);
    repeat (20) io(f);
    chk(32'(o.ch[0] < f.ch[0]), 32'h1);
    report_and_stop();
  end
endmodule : test_mute_and_peak_limiter
`default_nettype wire
